// File: ira_consts.svh
// Constants for the indirect register bank: rates, divides and addresses.
`ifndef IRA_CONSTS_SVH
`define IRA_CONSTS_SVH

// Clock and tick rates in hertz.
`define IRA_MCLK_HZ 100000000
`define IRA_UPDATE_HZ 16000
`define IRA_TONE_HZ 8000
`define IRA_FSK_HZ 24000

// Cycles of mclk per tick, derived from the rates above.
`define IRA_UPDATE_DIV (`IRA_MCLK_HZ / `IRA_UPDATE_HZ)
`define IRA_TONE_DIV (`IRA_MCLK_HZ / `IRA_TONE_HZ)
`define IRA_FSK_DIV (`IRA_MCLK_HZ / `IRA_FSK_HZ)

// Geometry of the indirect memory.
`define IRA_ADDR_W 7
`define IRA_WORD_W 16
`define IRA_DEPTH 128
`define IRA_RING_OFS_W 6

// Indirect addresses of the oscillator bank.
`define IRA_ADDR_TONE1_FREQ 7'h00
`define IRA_ADDR_TONE1_AMP 7'h01
`define IRA_ADDR_TONE1_PHASE 7'h02
`define IRA_ADDR_TONE2_FREQ 7'h03
`define IRA_ADDR_TONE2_AMP 7'h04
`define IRA_ADDR_TONE2_PHASE 7'h05
`define IRA_ADDR_RING_OFS 7'h06
`define IRA_ADDR_RING_FREQ 7'h07
`define IRA_ADDR_RING_AMP 7'h08
`define IRA_ADDR_RING_PHASE 7'h09

// Indirect addresses of other banks, kept at the new numbering.
`define IRA_ADDR_RX_GAIN 7'h0D
`define IRA_ADDR_TX_GAIN 7'h0E
`define IRA_ADDR_LINE_FIRST 7'h0F
`define IRA_ADDR_LINE_LAST 7'h1B
`define IRA_ADDR_MIN_VOLT 7'h40
`define IRA_ADDR_LOW_LOOP 7'h42

// Dedicated FSK oscillator set.
`define IRA_ADDR_FSK0_AMP 7'h45
`define IRA_ADDR_FSK0_FREQ 7'h46
`define IRA_ADDR_FSK1_AMP 7'h47
`define IRA_ADDR_FSK1_FREQ 7'h48
`define IRA_ADDR_FSK01 7'h49
`define IRA_ADDR_FSK10 7'h4A

// Reset values of the direct window registers.
`define IRA_DATA_RESET 16'h0000
`define IRA_ADDR_RESET 7'h00

`endif

// File: ira_pkg.sv
// Types shared by the indirect register bank modules.
package ira_pkg;

	typedef logic [6:0] ira_addr_t;
	typedef logic [15:0] ira_word_t;
	typedef logic signed [15:0] ira_coef_t;

	// Request state: idle, read pending, write pending.
	typedef enum logic [2:0] {
		IRA_IDLE = 3'b001,
		IRA_READ = 3'b010,
		IRA_WRITE = 3'b100
	} ira_req_t;

endpackage : ira_pkg

// File: ira_mem_if.sv
// Interface between the request controller and the indirect memory.
`timescale 1ns/1ns
interface ira_mem_if;
	import ira_pkg::*;

	logic wr_en;
	ira_addr_t addr;
	ira_word_t wdata;
	ira_word_t rdata;
	ira_word_t word [0:127];

	modport ctl (output wr_en, output addr, output wdata, input rdata,
		input word);
	modport mem (input wr_en, input addr, input wdata, output rdata,
		output word);
endinterface : ira_mem_if

// File: ira_tick.sv
// Free-running divider that emits a one-cycle tick every DIV clocks.
`timescale 1ns/1ns
module ira_tick
	import ira_pkg::*;
#(
	parameter int unsigned DIV = 16
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Tick out.
	output logic tick
);

	logic [15:0] count;

	// Count down and pulse when the count wraps.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 16'h0000;
			tick <= 1'b0;
		end else if (count == 16'h0000) begin
			count <= 16'(DIV - 1);
			tick <= 1'b1;
		end else begin
			count <= count - 16'h0001;
			tick <= 1'b0;
		end
	end

endmodule : ira_tick

// File: ira_mem.sv
// Indirect memory: flip-flop storage with one write and one read port.
`timescale 1ns/1ns
module ira_mem
	import ira_pkg::*;
(
	// Clock.
	input wire logic mclk,
	// Controller side.
	ira_mem_if.mem port
);

	// Storage has no reset, so its contents are undefined at start.
	genvar i;
	generate
		for (i = 0; i < 128; i++) begin : g_word
			always_ff @(posedge mclk) begin
				if (port.wr_en && port.addr == 7'(i)) begin
					port.word[i] <= port.wdata;
				end
			end
		end
	endgenerate

	// All sixteen bits read back, used or not.
	assign port.rdata = port.word[port.addr];

endmodule : ira_mem

// File: ira_bank.sv
// Indirect register bank with the oscillator coefficient outputs.
//
// Operation
// - Data window write then address write stores data at next update tick.
// - Address write alone loads addressed value into data window at next tick.
// - Pending transfers are serviced only on 16 kHz ticks, one per tick.
// - Pending flag stays one from request until the transfer is serviced.
// - A done pulse is raised when a read or write transfer finishes.
// - Indirect memory is not reset; host must program values before use.
// - All oscillator coefficients are two's-complement signed values.
// - Addresses 0, 1, 2 hold tone one frequency, amplitude and phase.
// - Addresses 3, 4, 5 hold tone two frequency, amplitude and phase.
// - Addresses 7, 8, 9 hold ringing frequency, amplitude and phase.
// - Address 6 holds the six-bit ringing offset, 1.5 V per step.
// - Gains, thresholds, voltage and FSK set sit at their new addresses.
// - With FSK enhance and relay bit, tone one runs at 24 kHz on FSK set.
`timescale 1ns/1ns
`include "ira_consts.svh"
module ira_bank
	import ira_pkg::*;
#(
	parameter int unsigned UPDATE_DIV = `IRA_UPDATE_DIV,
	parameter int unsigned TONE_DIV = `IRA_TONE_DIV,
	parameter int unsigned FSK_DIV = `IRA_FSK_DIV
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Direct window register writes from the host port.
	// Strobes are one-cycle pulses; an address write starts a request.
	input wire logic data_window_we,
	input wire ira_word_t data_window_wdata,
	input wire logic addr_window_we,
	input wire ira_addr_t addr_window_wdata,
	// Direct window register state.
	output ira_word_t indirect_data_window,
	output ira_addr_t indirect_address_window,
	output logic indirect_pending_flag,
	output logic indirect_done_interrupt,
	// Tone generator mode control.
	input wire logic fsk_enhance_enable,
	input wire logic relay_control_bit,
	// Tone generator one.
	output logic tone1_tick,
	output logic tone1_fsk_mode,
	output ira_coef_t tone1_freq_coef,
	output ira_coef_t tone1_amplitude,
	output ira_coef_t tone1_init_phase,
	// FSK second-symbol and transition words.
	// They feed the FSK symbol sequencer and are not switched here.
	output ira_coef_t fsk1_freq_coef,
	output ira_coef_t fsk1_amplitude,
	output ira_coef_t fsk_trans01,
	output ira_coef_t fsk_trans10,
	// Tone generator two.
	output logic tone2_tick,
	output ira_coef_t tone2_freq_coef,
	output ira_coef_t tone2_amplitude,
	output ira_coef_t tone2_init_phase,
	// Ringing generator.
	output ira_coef_t ring_freq_coef,
	output ira_coef_t ring_amplitude,
	output ira_coef_t ring_init_phase,
	output logic [5:0] ring_dc_offset,
	// Gain and line-control words for the neighbouring blocks.
	output ira_coef_t receive_gain,
	output ira_coef_t transmit_gain,
	output ira_coef_t minimum_voltage_setting,
	output ira_coef_t lower_loop_threshold
);

	// Memory port shared with the storage module.
	ira_mem_if mem_bus ();

	// Tick strobes for updates and tone generators. The dividers run free
	// from reset, so a request may wait up to one whole update period.
	logic update_tick;
	logic tone_tick;
	logic fsk_tick;

	// Request tracking. The host sees only the two window registers, so
	// the controller keeps one request at a time. The last address write
	// decides whether it is a read or a write, and the window registers
	// are used as they stand at the service tick. A host that rewrites a
	// window while a request is pending changes what that request does.
	ira_req_t req;
	ira_req_t next_req;
	logic data_written;
	logic want_write;
	logic service;

	// FSK mode decode.
	logic fsk_select;

	// Update tick at 16 kHz paces every indirect transfer.
	ira_tick #(
		.DIV(UPDATE_DIV)
	) u_update_tick (
		.mclk(mclk),
		.reset_n(reset_n),
		.tick(update_tick)
	);

	// Normal tone generator clock at 8 kHz.
	ira_tick #(
		.DIV(TONE_DIV)
	) u_tone_tick (
		.mclk(mclk),
		.reset_n(reset_n),
		.tick(tone_tick)
	);

	// Enhanced FSK tone generator clock at 24 kHz.
	ira_tick #(
		.DIV(FSK_DIV)
	) u_fsk_tick (
		.mclk(mclk),
		.reset_n(reset_n),
		.tick(fsk_tick)
	);

	// Indirect storage.
	ira_mem u_mem (
		.mclk(mclk),
		.port(mem_bus.mem)
	);

	// A request is serviced only on an update tick, one per tick.
	// The tick is one clock wide, so two transfers never share a tick.
	assign service = update_tick && (req != IRA_IDLE);

	// A data write in the same cycle as the address write counts as first.
	// Without this term a write given with its address would become a read.
	assign want_write = data_written || data_window_we;

	// Next request state. A new address write wins over the clear, so a
	// request that lands on the service edge stays pending for the next
	// tick while the old one completes. A request replaced before its
	// tick is dropped without a done pulse.
	always_comb begin
		next_req = req;
		unique case (req)
			IRA_IDLE: begin
				next_req = IRA_IDLE;
			end
			IRA_READ, IRA_WRITE: begin
				if (service) begin
					next_req = IRA_IDLE;
				end
			end
		endcase
		if (addr_window_we) begin
			if (want_write) begin
				next_req = IRA_WRITE;
			end else begin
				next_req = IRA_READ;
			end
		end
	end

	// Request state register.
	// Reset leaves it idle, so nothing is serviced before the host asks.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			req <= IRA_IDLE;
		end else begin
			req <= next_req;
		end
	end

	// Record of a data window write since the last address write.
	// The clear wins, since a data write in that cycle already counts above.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			data_written <= 1'b0;
		end else if (addr_window_we) begin
			data_written <= 1'b0;
		end else if (data_window_we) begin
			data_written <= 1'b1;
		end
	end

	// Address window register.
	// It keeps the last address written, pending or already serviced.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			indirect_address_window <= `IRA_ADDR_RESET;
		end else if (addr_window_we) begin
			indirect_address_window <= addr_window_wdata;
		end
	end

	// Data window: host writes win over a read completing in that cycle.
	// The read still completes and pulses done, so a host should not
	// write the data window while a read is pending.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			indirect_data_window <= `IRA_DATA_RESET;
		end else if (data_window_we) begin
			indirect_data_window <= data_window_wdata;
		end else if (service && req == IRA_READ) begin
			indirect_data_window <= mem_bus.rdata;
		end
	end

	// Memory access uses the window registers as they stand.
	// A write therefore stores whatever the data window holds at the tick.
	assign mem_bus.wr_en = service && (req == IRA_WRITE);
	assign mem_bus.addr = indirect_address_window;
	assign mem_bus.wdata = indirect_data_window;

	// Pending flag follows the request state from the same edge.
	// Taking next_req keeps the flag level with req, with no extra cycle.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			indirect_pending_flag <= 1'b0;
		end else begin
			indirect_pending_flag <= (next_req != IRA_IDLE);
		end
	end

	// One-cycle completion pulse for the interrupt status logic.
	// Status and mask logic outside this block turns it into a sticky bit.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			indirect_done_interrupt <= 1'b0;
		end else begin
			indirect_done_interrupt <= service;
		end
	end

	// FSK enhancement applies only while the relay bit is set.
	// Enhance alone leaves tone one on its normal clock and coefficients.
	assign fsk_select = fsk_enhance_enable && relay_control_bit;

	// Tone generator one clock selection and mode flag.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tone1_fsk_mode <= 1'b0;
			tone1_tick <= 1'b0;
		end else begin
			tone1_fsk_mode <= fsk_select;
			tone1_tick <= fsk_select ? fsk_tick : tone_tick;
		end
	end

	// Tone generator two always runs from the normal clock.
	// It is registered like tone one so both ticks keep the same delay.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tone2_tick <= 1'b0;
		end else begin
			tone2_tick <= tone_tick;
		end
	end

	// Tone one coefficients, swapped for the FSK set in enhanced mode.
	// The FSK set has no phase word, so the normal phase word is kept.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tone1_freq_coef <= 16'sh0000;
			tone1_amplitude <= 16'sh0000;
			tone1_init_phase <= 16'sh0000;
		end else if (fsk_select) begin
			tone1_freq_coef <= mem_bus.word[`IRA_ADDR_FSK0_FREQ];
			tone1_amplitude <= mem_bus.word[`IRA_ADDR_FSK0_AMP];
			tone1_init_phase <= mem_bus.word[`IRA_ADDR_TONE1_PHASE];
		end else begin
			tone1_freq_coef <= mem_bus.word[`IRA_ADDR_TONE1_FREQ];
			tone1_amplitude <= mem_bus.word[`IRA_ADDR_TONE1_AMP];
			tone1_init_phase <= mem_bus.word[`IRA_ADDR_TONE1_PHASE];
		end
	end

	// Remaining FSK words, used by the FSK symbol sequencer.
	// They follow storage in every mode, so they can be set up in advance.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fsk1_freq_coef <= 16'sh0000;
			fsk1_amplitude <= 16'sh0000;
			fsk_trans01 <= 16'sh0000;
			fsk_trans10 <= 16'sh0000;
		end else begin
			fsk1_freq_coef <= mem_bus.word[`IRA_ADDR_FSK1_FREQ];
			fsk1_amplitude <= mem_bus.word[`IRA_ADDR_FSK1_AMP];
			fsk_trans01 <= mem_bus.word[`IRA_ADDR_FSK01];
			fsk_trans10 <= mem_bus.word[`IRA_ADDR_FSK10];
		end
	end

	// Tone two coefficients, signed values straight from storage.
	// A new word reaches the outputs one clock after it is stored.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tone2_freq_coef <= 16'sh0000;
			tone2_amplitude <= 16'sh0000;
			tone2_init_phase <= 16'sh0000;
		end else begin
			tone2_freq_coef <= mem_bus.word[`IRA_ADDR_TONE2_FREQ];
			tone2_amplitude <= mem_bus.word[`IRA_ADDR_TONE2_AMP];
			tone2_init_phase <= mem_bus.word[`IRA_ADDR_TONE2_PHASE];
		end
	end

	// Ringing oscillator coefficients, read as two's complement.
	// Until the host programs them they carry whatever storage holds.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ring_freq_coef <= 16'sh0000;
			ring_amplitude <= 16'sh0000;
			ring_init_phase <= 16'sh0000;
		end else begin
			ring_freq_coef <= mem_bus.word[`IRA_ADDR_RING_FREQ];
			ring_amplitude <= mem_bus.word[`IRA_ADDR_RING_AMP];
			ring_init_phase <= mem_bus.word[`IRA_ADDR_RING_PHASE];
		end
	end

	// Ringing offset takes the low six bits; upper bits are storage only.
	// One step of the field is 1.5 V of offset on the ringing waveform.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ring_dc_offset <= 6'h00;
		end else begin
			ring_dc_offset <=
				mem_bus.word[`IRA_ADDR_RING_OFS][`IRA_RING_OFS_W-1:0];
		end
	end

	// Gain and line-control words at their current addresses.
	// Their fields are narrower than a word; the users take what they need.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			receive_gain <= 16'sh0000;
			transmit_gain <= 16'sh0000;
			minimum_voltage_setting <= 16'sh0000;
			lower_loop_threshold <= 16'sh0000;
		end else begin
			receive_gain <= mem_bus.word[`IRA_ADDR_RX_GAIN];
			transmit_gain <= mem_bus.word[`IRA_ADDR_TX_GAIN];
			minimum_voltage_setting <= mem_bus.word[`IRA_ADDR_MIN_VOLT];
			lower_loop_threshold <= mem_bus.word[`IRA_ADDR_LOW_LOOP];
		end
	end

endmodule : ira_bank

// File: ira_monitor.sv
// Checker for the window handshake of the indirect register bank.
`timescale 1ns/1ns
module ira_monitor
	import ira_pkg::*;
#(
	parameter int UPDATE_DIV = 8
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Host window writes and mode inputs.
	input wire logic data_window_we,
	input wire ira_word_t data_window_wdata,
	input wire logic addr_window_we,
	input wire ira_addr_t addr_window_wdata,
	input wire logic fsk_enhance_enable,
	input wire logic relay_control_bit,
	// Window state and status.
	input wire ira_word_t indirect_data_window,
	input wire ira_addr_t indirect_address_window,
	input wire logic indirect_pending_flag,
	input wire logic indirect_done_interrupt,
	input wire logic tone1_fsk_mode
);
	// A request waits at most one tick period plus the done edge.
	localparam int MAX_W = UPDATE_DIV + 1;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Service step: pending drops while done pulses.
	sequence s_serve;
		!indirect_pending_flag && indirect_done_interrupt;
	endsequence
	property p_pend_set;
		addr_window_we |=> indirect_pending_flag;
	endproperty
	a_pend_set: assert property (p_pend_set)
		else $error("pending flag not raised by address write");
	property p_serve;
		$rose(indirect_pending_flag) |-> ##[1:MAX_W] s_serve;
	endproperty
	a_serve: assert property (p_serve)
		else $error("request not serviced within one tick period");
	property p_fall;
		$fell(indirect_pending_flag) |-> indirect_done_interrupt;
	endproperty
	a_fall: assert property (p_fall)
		else $error("pending cleared without done pulse");
	property p_done_cause;
		indirect_done_interrupt |-> $past(indirect_pending_flag);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("done pulse with nothing pending");
	property p_one_per_tick;
		indirect_done_interrupt |=> !indirect_done_interrupt [*7];
	endproperty
	a_one_per_tick: assert property (p_one_per_tick)
		else $error("two transfers completed in one tick period");
	property p_addr_win;
		addr_window_we |=> indirect_address_window ==
			$past(addr_window_wdata);
	endproperty
	a_addr_win: assert property (p_addr_win)
		else $error("address window did not take written address");
	property p_data_win;
		data_window_we |=> indirect_data_window == $past(data_window_wdata);
	endproperty
	a_data_win: assert property (p_data_win)
		else $error("data window did not take written data");
	property p_data_hold;
		!$stable(indirect_data_window) |->
			$past(data_window_we) || indirect_done_interrupt;
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("data window changed without write or read");
	property p_fsk;
		fsk_enhance_enable && relay_control_bit |=> tone1_fsk_mode;
	endproperty
	a_fsk: assert property (p_fsk)
		else $error("tone one not switched to fsk mode");
endmodule : ira_monitor

// File: ira_host.sv
// Host model that reaches the indirect bank through its window registers.
`timescale 1ns/1ns
module ira_host
	import ira_pkg::*;
(
	// Clock.
	input wire logic mclk,
	// Window writes.
	output logic data_window_we,
	output ira_word_t data_window_wdata,
	output logic addr_window_we,
	output ira_addr_t addr_window_wdata,
	// Status from the bank.
	input wire ira_word_t indirect_data_window,
	input wire logic indirect_done_interrupt
);
	// Strobes idle low at time zero.
	initial begin
		data_window_we = 1'b0;
		addr_window_we = 1'b0;
		data_window_wdata = 16'h0000;
		addr_window_wdata = 7'h00;
	end
	// Data write first (wr 01) or with the address (wr 11), else a read.
	task automatic xfer(input logic [1:0] wr, input ira_addr_t a,
		input ira_word_t d, output ira_word_t q, output logic ok);
		int n;
		ok = 1'b0;
		q = 16'h0000;
		if (wr == 2'b01) begin
			data_window_wdata = d;
			data_window_we = 1'b1;
			@(posedge mclk);
			#1;
			data_window_we = 1'b0;
			data_window_wdata = ~d; // Stale data is inverted once released.
		end
		if (wr == 2'b11) begin
			data_window_wdata = d;
			data_window_we = 1'b1;
		end
		addr_window_wdata = a;
		addr_window_we = 1'b1;
		@(posedge mclk);
		#1;
		if (wr == 2'b11) begin
			data_window_we = 1'b0;
			data_window_wdata = ~d;
		end
		addr_window_we = 1'b0;
		addr_window_wdata = ~a;
		for (n = 0; n < 12 && !ok; n++) begin
			@(posedge mclk);
			#1;
			if (indirect_done_interrupt === 1'b1) begin
				ok = 1'b1;
				q = indirect_data_window;
			end
		end
	endtask : xfer
endmodule : ira_host

// File: testbench.sv
// Self-checking bench for the indirect register bank.
`timescale 1ns/1ns
module testbench;
	import ira_pkg::*;
	localparam int UPDATE_DIV = 8;
	localparam int FSK_DIV = 8;
	localparam int TONE_DIV = 24;
	logic mclk, reset_n, fsk_enhance_enable, relay_control_bit, ok;
	logic data_window_we, addr_window_we, indirect_pending_flag;
	logic indirect_done_interrupt, tone1_tick, tone1_fsk_mode, tone2_tick;
	ira_word_t data_window_wdata, indirect_data_window, q;
	ira_addr_t addr_window_wdata, indirect_address_window;
	logic [5:0] ring_dc_offset;
	ira_coef_t tone1_freq_coef, tone1_amplitude, tone1_init_phase;
	ira_coef_t fsk1_freq_coef, fsk1_amplitude, fsk_trans01, fsk_trans10;
	ira_coef_t tone2_freq_coef, tone2_amplitude, tone2_init_phase;
	ira_coef_t ring_freq_coef, ring_amplitude, ring_init_phase;
	ira_coef_t receive_gain, transmit_gain;
	ira_coef_t minimum_voltage_setting, lower_loop_threshold;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 32'hb0ae242a;
	int mdl [128];
	int lst [10] = '{13, 14, 64, 66, 69, 70, 71, 72, 73, 74};
	int n, i, a;
	ira_bank #(.UPDATE_DIV(UPDATE_DIV), .TONE_DIV(TONE_DIV),
		.FSK_DIV(FSK_DIV)) uut (.mclk, .reset_n, .data_window_we,
		.data_window_wdata, .addr_window_we, .addr_window_wdata,
		.indirect_data_window, .indirect_address_window,
		.indirect_pending_flag, .indirect_done_interrupt,
		.fsk_enhance_enable, .relay_control_bit, .tone1_tick,
		.tone1_fsk_mode, .tone1_freq_coef, .tone1_amplitude,
		.tone1_init_phase, .fsk1_freq_coef, .fsk1_amplitude, .fsk_trans01,
		.fsk_trans10, .tone2_tick, .tone2_freq_coef, .tone2_amplitude,
		.tone2_init_phase, .ring_freq_coef, .ring_amplitude,
		.ring_init_phase, .ring_dc_offset, .receive_gain, .transmit_gain,
		.minimum_voltage_setting, .lower_loop_threshold);
	ira_host host (.mclk, .data_window_we, .data_window_wdata,
		.addr_window_we, .addr_window_wdata, .indirect_data_window,
		.indirect_done_interrupt);
	// Clock of 10 ns period.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Cut a hung run short.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			$display("[FAIL] run timed out");
			final_report();
		end
	end
	// Compare one value and count the result.
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One transfer through the host model, mirrored in the model memory.
	task automatic op(input logic [1:0] wr, input int ad, input int d);
		host.xfer(wr, ad[6:0], d[15:0], q, ok);
		check("done", {15'h0000, ok}, 16'h0001);
		if (wr[0]) begin
			mdl[ad] = d & 32'hFFFF;
		end else begin
			check("read", q, mdl[ad][15:0]);
		end
	endtask : op
	// Count tone one ticks over a whole number of periods.
	task automatic ticks(input int exp);
		int m;
		n = 0;
		m = 0;
		repeat (96) begin
			@(posedge mclk);
			#1;
			n += tone1_tick;
			m += tone2_tick;
		end
		check("tone1 ticks", n[15:0], exp[15:0]);
		check("tone2 ticks", m[15:0], 16'(96 / TONE_DIV));
	endtask : ticks
	// Print the counts and the verdict, then stop.
	task automatic final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	// Main sequence.
	initial begin
		reset_n = 1'b0;
		fsk_enhance_enable = 1'b0;
		relay_control_bit = 1'b0;
		repeat (6) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		for (a = 0; a < 10; a++) begin
			n = $random(seed);
			op(2'b01, a, (a == 6) ? (n & 32'h3F) : n);
		end
		repeat (2) @(posedge mclk);
		#1;
		check("t1f", tone1_freq_coef, mdl[0][15:0]);
		check("t1a", tone1_amplitude, mdl[1][15:0]);
		check("t1p", tone1_init_phase, mdl[2][15:0]);
		check("t2f", tone2_freq_coef, mdl[3][15:0]);
		check("t2a", tone2_amplitude, mdl[4][15:0]);
		check("t2p", tone2_init_phase, mdl[5][15:0]);
		check("rofs", {10'h000, ring_dc_offset}, mdl[6][15:0]);
		check("rf", ring_freq_coef, mdl[7][15:0]);
		check("ra", ring_amplitude, mdl[8][15:0]);
		check("rp", ring_init_phase, mdl[9][15:0]);
		for (a = 0; a < 10; a++) begin
			op(2'b00, a, 0);
		end
		$display("test oscillator bank done");
		for (i = 0; i < 10; i++) begin
			op(2'b01, lst[i], $random(seed));
		end
		fsk_enhance_enable = 1'b1;
		relay_control_bit = 1'b1;
		repeat (30) @(posedge mclk);
		#1;
		check("rxg", receive_gain, mdl[13][15:0]);
		check("txg", transmit_gain, mdl[14][15:0]);
		check("vmin", minimum_voltage_setting, mdl[64][15:0]);
		check("lowl", lower_loop_threshold, mdl[66][15:0]);
		check("fskf", tone1_freq_coef, mdl[70][15:0]);
		check("fska", tone1_amplitude, mdl[69][15:0]);
		check("fskp", tone1_init_phase, mdl[2][15:0]);
		check("fsk1f", fsk1_freq_coef, mdl[72][15:0]);
		check("fsk1a", fsk1_amplitude, mdl[71][15:0]);
		check("fsk01", fsk_trans01, mdl[73][15:0]);
		check("fsk10", fsk_trans10, mdl[74][15:0]);
		ticks(96 / FSK_DIV);
		relay_control_bit = 1'b0;
		repeat (30) @(posedge mclk);
		#1;
		check("t1f norm", tone1_freq_coef, mdl[0][15:0]);
		check("t1a norm", tone1_amplitude, mdl[1][15:0]);
		ticks(96 / TONE_DIV);
		$display("test address map and fsk done");
		repeat (30) begin
			a = ($random(seed) & 32'h7FFFFFFF) % 10;
			n = $random(seed);
			op(n[21:20], a, (a == 6) ? (n & 32'h3F) : n);
		end
		$display("test random transfers done");
		final_report();
	end
endmodule : testbench
// Attach the checker to the bank.
bind ira_bank ira_monitor #(.UPDATE_DIV(UPDATE_DIV)) mon (.mclk, .reset_n,
	.data_window_we, .data_window_wdata, .addr_window_we,
	.addr_window_wdata, .fsk_enhance_enable, .relay_control_bit,
	.indirect_data_window, .indirect_address_window,
	.indirect_pending_flag, .indirect_done_interrupt, .tone1_fsk_mode);
